/* core/ifc_pkg.sv */
// constants and types of the interrupt flag control block
package ifc_pkg;

    // ------------------------------------------------------------
    // register indices, byte address is four times the index
    // ------------------------------------------------------------
    localparam logic [7:0] control_index_bank0 = 8'h0B;
    localparam logic [7:0] control_index_bank1 = 8'h8B;
    localparam logic [7:0] event_status_index = 8'h10;
    localparam logic [7:0] event_mask_index = 8'h11;

    // ------------------------------------------------------------
    // control register bit positions
    // ------------------------------------------------------------
    localparam int global_irq_enable_bit = 7;
    localparam int reserved_bit = 6;
    localparam int timer_overflow_enable_bit = 5;
    localparam int external_pin_enable_bit = 4;
    localparam int port_change_irq_enable_bit = 3;
    localparam int timer_overflow_flag_bit = 2;
    localparam int external_pin_event_flag_bit = 1;
    localparam int port_change_flag_bit = 0;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] control_reset = 8'h00;
    localparam logic [2:0] event_status_reset = 3'h0;
    localparam logic [2:0] event_mask_reset = 3'h0;

    // ------------------------------------------------------------
    // state of the register block
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] interrupt_control_flags;
        logic [2:0] event_status;
        logic [2:0] event_mask;
        logic ack;
        logic [31:0] read_data;
        logic core_irq;
        logic event_irq;
    } ifc_state_type;

    typedef struct packed {
        logic primed;
        logic last_pin;
        logic [3:0] last_port;
        logic pin_event;
        logic port_event;
    } ifc_detect_type;

endpackage : ifc_pkg

/* core/ifc_event_detect.sv */
// edge and change detector for the interrupt pin and upper port pins
`timescale 1ns/1ps
module ifc_event_detect
(
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // pins
    input wire logic external_irq_pin,
    input wire logic [3:0] upper_port_pins,
    // one-cycle events
    output logic pin_event,
    output logic port_event
);

    ifc_pkg::ifc_detect_type state;
    ifc_pkg::ifc_detect_type next_state;

    // ------------------------------------------------------------
    // detection
    // ------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        next_state.primed = 1'b1;
        next_state.last_pin = external_irq_pin;
        next_state.last_port = upper_port_pins;
        // rising edge on the interrupt pin
        next_state.pin_event = state.primed & external_irq_pin & ~state.last_pin;
        // any upper pin differs from its last value
        next_state.port_event = state.primed & (|(upper_port_pins ^ state.last_port));
    end

    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign pin_event = state.pin_event;
    assign port_event = state.port_event;

endmodule : ifc_event_detect

/* core/ifc_interrupt_control.sv */
// interrupt flag and enable control register with wishbone access
//
// Local design decision: register access over Wishbone.
`timescale 1ns/1ps
module ifc_interrupt_control
(
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [9:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // event sources
    input wire logic timer_overflow_pulse,
    input wire logic external_irq_pin,
    input wire logic [3:0] upper_port_pins,
    // interrupt outputs
    output logic core_irq,
    output logic event_irq,
    // register view
    output logic [7:0] interrupt_control_flags
);

    ifc_pkg::ifc_state_type state;
    ifc_pkg::ifc_state_type next_state;
    logic pin_event;
    logic port_event;

    // ------------------------------------------------------------
    // pin event detection
    // ------------------------------------------------------------
    ifc_event_detect detect
    (
        .clock(clock),
        .rstn(rstn),
        .external_irq_pin(external_irq_pin),
        .upper_port_pins(upper_port_pins),
        .pin_event(pin_event),
        .port_event(port_event)
    );

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    // a register word sits at four times its index, low address bits zero
    function automatic logic is_index(input logic [9:0] adr, input logic [7:0] index);
        is_index = (adr[9:2] == index) && (adr[1:0] == 2'h0);
    endfunction : is_index

    // ------------------------------------------------------------
    // register access helpers
    // ------------------------------------------------------------
    // one 8-bit register per bus word, the upper bits read zero
    function automatic logic [31:0] read_word(input logic [7:0] value);
        read_word = {24'h000000, value};
    endfunction : read_word

    // sticky event bits: a set in the same cycle as a clear wins
    function automatic logic [2:0] sticky(input logic [2:0] held, input logic [2:0] clear, input logic [2:0] raise);
        sticky = (held & ~clear) | raise;
    endfunction : sticky

    // place each event at its flag position
    function automatic logic [7:0] event_bits(input logic timer, input logic pin, input logic port);
        event_bits = 8'h00;
        event_bits[ifc_pkg::timer_overflow_flag_bit] = timer;
        event_bits[ifc_pkg::external_pin_event_flag_bit] = pin;
        event_bits[ifc_pkg::port_change_flag_bit] = port;
    endfunction : event_bits

    // ------------------------------------------------------------
    // interrupt request decode
    // ------------------------------------------------------------
    // one source asks when its flag and its enable are both set
    function automatic logic source_pending(input logic [7:0] flags, input int enable_bit, input int flag_bit);
        source_pending = flags[enable_bit] & flags[flag_bit];
    endfunction : source_pending

    // global enable and any flag with its own enable
    function automatic logic core_request(input logic [7:0] flags);
        logic pending;
        pending = source_pending(flags, ifc_pkg::timer_overflow_enable_bit,
                                 ifc_pkg::timer_overflow_flag_bit) |
                  source_pending(flags, ifc_pkg::external_pin_enable_bit,
                                 ifc_pkg::external_pin_event_flag_bit) |
                  source_pending(flags, ifc_pkg::port_change_irq_enable_bit,
                                 ifc_pkg::port_change_flag_bit);
        core_request = flags[ifc_pkg::global_irq_enable_bit] & pending;
    endfunction : core_request

    // status bits that their mask lets through
    function automatic logic masked_request(input logic [2:0] status, input logic [2:0] mask);
        masked_request = |(status & mask);
    endfunction : masked_request

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        logic request;
        logic write_lane;
        logic hit_control;
        logic hit_status;
        logic hit_mask;
        logic [2:0] events;
        logic [7:0] control;
        logic [7:0] flags_set;
        logic [2:0] status_clear;
        request = 1'b0;
        write_lane = 1'b0;
        hit_control = 1'b0;
        hit_status = 1'b0;
        hit_mask = 1'b0;
        events = 3'h0;
        control = 8'h00;
        flags_set = 8'h00;
        status_clear = 3'h0;
        next_state = state;

        request = cyc_i & stb_i & ~state.ack;
        write_lane = request & we_i & sel_i[0];
        hit_control = is_index(adr_i, ifc_pkg::control_index_bank0) |
                      is_index(adr_i, ifc_pkg::control_index_bank1);
        hit_status = is_index(adr_i, ifc_pkg::event_status_index);
        hit_mask = is_index(adr_i, ifc_pkg::event_mask_index);

        // events set flags whatever the enables say
        flags_set = event_bits(timer_overflow_pulse, pin_event, port_event);
        events = flags_set[2:0];

        // software write first, hardware set wins over a cleared bit
        control = state.interrupt_control_flags;
        if (write_lane && hit_control)
        begin
            control = dat_i[7:0];
        end
        control[ifc_pkg::reserved_bit] = 1'b0;
        next_state.interrupt_control_flags = control | flags_set;

        if (write_lane && hit_status)
        begin
            status_clear = dat_i[2:0];
        end
        next_state.event_status = sticky(state.event_status, status_clear, events);
        if (write_lane && hit_mask)
        begin
            next_state.event_mask = dat_i[2:0];
        end

        // one-cycle acknowledge, unmapped reads return zero
        next_state.ack = request;
        next_state.read_data = 32'h00000000;
        if (request && !we_i)
        begin
            if (hit_control)
            begin
                next_state.read_data = read_word(state.interrupt_control_flags);
            end
            else if (hit_status)
            begin
                next_state.read_data = read_word({5'h00, state.event_status});
            end
            else if (hit_mask)
            begin
                next_state.read_data = read_word({5'h00, state.event_mask});
            end
        end

        // request to the core
        next_state.core_irq = core_request(state.interrupt_control_flags);
        next_state.event_irq = masked_request(state.event_status, state.event_mask);
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            state.interrupt_control_flags <= ifc_pkg::control_reset;
            state.event_status <= ifc_pkg::event_status_reset;
            state.event_mask <= ifc_pkg::event_mask_reset;
            state.ack <= 1'b0;
            state.read_data <= 32'h00000000;
            state.core_irq <= 1'b0;
            state.event_irq <= 1'b0;
        end
        else
        begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign dat_o = state.read_data;
    assign ack_o = state.ack;
    assign core_irq = state.core_irq;
    assign event_irq = state.event_irq;
    assign interrupt_control_flags = state.interrupt_control_flags;

endmodule : ifc_interrupt_control

/* tb/ifc_event_src.sv */
// model of the timer and pin event sources
`timescale 1ns/1ps
module ifc_event_src
(
    // clock
    input wire logic clock,
    // requests from the bench
    input wire logic fire,
    input wire logic pin_req,
    input wire logic [3:0] port_req,
    // source outputs
    output logic timer_overflow_pulse,
    output logic external_irq_pin,
    output logic [3:0] upper_port_pins
);
    always_ff @(posedge clock)
    begin
        timer_overflow_pulse <= fire;
        external_irq_pin <= pin_req;
        upper_port_pins <= port_req;
    end
endmodule : ifc_event_src

/* tb/ifc_interrupt_control_asserts.sv */
// assertions for the interrupt flag control block
`timescale 1ns/1ps
module ifc_interrupt_control_asserts
(
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // bus
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    // events and outputs
    input wire logic timer_overflow_pulse,
    input wire logic external_irq_pin,
    input wire logic [3:0] upper_port_pins,
    input wire logic core_irq,
    input wire logic [7:0] interrupt_control_flags
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);
    ack_once_a: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    ack_time_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("ack not one cycle after request");
    read_idle_a: assert property (!ack_o |-> dat_o == 32'h0)
        else $error("read data without ack");
    timer_flag_a: assert property (timer_overflow_pulse |=> interrupt_control_flags[2])
        else $error("timer flag not set");
    timer_hold_a: assert property (interrupt_control_flags[2] && !(cyc_i && stb_i && we_i)
        |=> interrupt_control_flags[2])
        else $error("timer flag cleared by itself");
    pin_flag_a: assert property ($rose(external_irq_pin) |-> ##[1:2] interrupt_control_flags[1])
        else $error("pin flag not set");
    port_flag_a: assert property (upper_port_pins != $past(upper_port_pins)
        |-> ##[1:2] interrupt_control_flags[0])
        else $error("port flag not set");
    core_irq_a: assert property (1'b1 |=> core_irq == $past(interrupt_control_flags[7]
        && |(interrupt_control_flags[5:3] & interrupt_control_flags[2:0])))
        else $error("core request wrong");
    reserved_bit_a: assert property (interrupt_control_flags[6] == 1'b0)
        else $error("reserved bit set");
    cover property (core_irq);
    cover property ($rose(external_irq_pin));
    cover property (ack_o && we_i);
endmodule : ifc_interrupt_control_asserts
bind ifc_interrupt_control ifc_interrupt_control_asserts ifc_interrupt_control_asserts_i (.clock(clock),
    .rstn(rstn), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .dat_o(dat_o), .ack_o(ack_o),
    .timer_overflow_pulse(timer_overflow_pulse), .external_irq_pin(external_irq_pin),
    .upper_port_pins(upper_port_pins), .core_irq(core_irq), .interrupt_control_flags(interrupt_control_flags));

/* tb/tb_ifc_interrupt_control.sv */
// testbench of the interrupt flag control block
`timescale 1ns/1ps
module tb_ifc_interrupt_control;
    logic clock = 1'b0, rstn = 1'b0, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, fire = 1'b0, pin_req = 1'b0;
    logic [9:0] adr_i = 10'h000;
    logic [3:0] sel_i = 4'h0, port_req = 4'h0, upper_port_pins;
    logic [31:0] dat_i = 32'h0, dat_o;
    logic ack_o, core_irq, event_irq, timer_overflow_pulse, external_irq_pin;
    logic [7:0] interrupt_control_flags;
    logic [7:0] notes[$];
    int miscompares = 0, checked = 0;
    integer seed = 32'h60A9;
    ifc_event_src ifc_event_src_i (.clock(clock), .fire(fire), .pin_req(pin_req), .port_req(port_req),
        .timer_overflow_pulse(timer_overflow_pulse), .external_irq_pin(external_irq_pin),
        .upper_port_pins(upper_port_pins));
    ifc_interrupt_control ifc_interrupt_control_i (.clock(clock), .rstn(rstn), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .timer_overflow_pulse(timer_overflow_pulse), .external_irq_pin(external_irq_pin),
        .upper_port_pins(upper_port_pins), .core_irq(core_irq), .event_irq(event_irq),
        .interrupt_control_flags(interrupt_control_flags));
    initial forever #2.5 clock = ~clock;
    task automatic note_miss(input string m);
        miscompares++;
        $display("mismatch %0t %s", $time, m);
    endtask : note_miss
    task automatic cmp_read(input logic [31:0] g, input logic [7:0] e);
        checked++;
        if (g !== {24'h000000, e})
            note_miss("read data");
    endtask : cmp_read
    task automatic cmp_view(input logic [7:0] e);
        @(negedge clock);
        checked++;
        if (interrupt_control_flags !== e)
            note_miss("register view");
    endtask : cmp_view
    task automatic cmp_irq(input logic c, input logic e);
        repeat (3) @(negedge clock);
        checked++;
        if (core_irq !== c || event_irq !== e)
            note_miss("irq level");
    endtask : cmp_irq
    task automatic wb(input logic w, input logic [9:0] a, input logic [7:0] d);
        @(posedge clock);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        sel_i <= 4'hF;
        dat_i <= {24'h0, d};
        do @(posedge clock); while (ack_o !== 1'b1);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask : wb
    task automatic rd(input logic [9:0] a, input logic [7:0] e);
        notes.push_back(e);
        wb(1'b0, a, 8'h00);
    endtask : rd
    task automatic ev(input logic t, input logic p, input logic [3:0] q);
        @(posedge clock);
        fire <= t;
        pin_req <= p;
        port_req <= q;
        @(posedge clock);
        fire <= 1'b0;
        repeat (4) @(posedge clock);
    endtask : ev
    task automatic end_of_test;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_of_test
    always @(posedge clock)
    begin
        if (ack_o === 1'b1 && we_i === 1'b0)
        begin
            if (notes.size() == 0)
                note_miss("unexpected read");
            else
                cmp_read(dat_o, notes.pop_front());
        end
    end
    initial
    begin
        #20000;
        miscompares++;
        end_of_test;
    end
    initial
    begin
        repeat (16) @(posedge clock);
        rstn <= 1'b1;
        rd(10'h02C, 8'h00);
        rd(10'h040, 8'h00);
        wb(1'b1, 10'h02C, 8'hF8);
        rd(10'h22C, 8'hB8);
        ev(1'b1, 1'b0, port_req);
        rd(10'h02C, 8'hBC);
        cmp_view(8'hBC);
        cmp_irq(1'b1, 1'b0);
        wb(1'b1, 10'h22C, 8'hB8);
        rd(10'h02C, 8'hB8);
        cmp_irq(1'b0, 1'b0);
        wb(1'b1, 10'h02C, 8'h00);
        ev(1'b0, 1'b1, port_req);
        rd(10'h02C, 8'h02);
        ev(1'b0, 1'b1, port_req ^ (4'($random(seed)) | 4'h1));
        rd(10'h02C, 8'h03);
        cmp_view(8'h03);
        cmp_irq(1'b0, 1'b0);
        wb(1'b1, 10'h044, 8'h07);
        cmp_irq(1'b0, 1'b1);
        rd(10'h044, 8'h07);
        wb(1'b1, 10'h040, 8'h07);
        rd(10'h040, 8'h00);
        cmp_irq(1'b0, 1'b0);
        wb(1'b1, 10'h22C, 8'h00);
        rd(10'h02C, 8'h00);
        rd(10'h3FC, 8'h00);
        repeat (4) @(posedge clock);
        end_of_test;
    end
endmodule : tb_ifc_interrupt_control
